/* File: core/fsw_poller.sv */
// Host-side poller that reads flash write status over the parallel pins.
// Assumes the flash pins are asynchronous; dq and ready/busy are synchronised.
`timescale 1ns/1ps
module fsw_poller (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire fsw_pkg::fsw_kind_e kind_i,
  input wire logic [fsw_pkg::ADDR_W-1:0] addr_i,
  input wire logic abandon_i,
  input wire logic [fsw_pkg::DATA_W-1:0] dq_i,
  input wire logic ready_busy_n_i,
  output fsw_pkg::fsw_pins_s pins_o,
  output logic busy_o,
  output logic done_o,
  output fsw_pkg::fsw_result_s result_o,
  output logic flash_ready_o
);
  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [fsw_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q;
  logic rb_s1_q, rb_s2_q;

  // Two stages on every pin; only the second stage is read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= ready_busy_n_i;
      rb_s2_q <= rb_s1_q;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_RD_ACT, ST_RD_GAP, ST_WR_ACT, ST_WR_GAP} fsw_state_e;
  fsw_state_e state_q, state_d;
  fsw_pkg::fsw_kind_e kind_q, kind_d;
  fsw_pkg::fsw_pins_s pins_q, pins_d;
  fsw_pkg::fsw_result_s res_q, res_d;
  logic [fsw_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [fsw_pkg::DATA_W-1:0] rd_q, rd_d;
  logic [fsw_pkg::DATA_W-1:0] cur_q, cur_d;
  logic [1:0] reads_q, reads_d;
  logic recheck_q, recheck_d;
  logic done_q, done_d;
  logic busy_q, busy_d;
  logic op_tog, est_tog;

  // Toggle comparison against the previous read
  assign op_tog = rd_q[fsw_pkg::OPERATION_TOGGLE_BIT] ^ cur_q[fsw_pkg::OPERATION_TOGGLE_BIT];
  assign est_tog = rd_q[fsw_pkg::ERASE_SECTOR_TOGGLE_BIT] ^ cur_q[fsw_pkg::ERASE_SECTOR_TOGGLE_BIT];

  // Next-state and pin computation
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    pins_d = pins_q;
    res_d = res_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    cur_d = cur_q;
    reads_d = reads_q;
    recheck_d = recheck_q;
    done_d = 1'b0;
    busy_d = busy_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_i) begin
          // Caller's address must be a valid status address in the busy bank
          kind_d = kind_i;
          pins_d.addr = addr_i;
          pins_d.ce_n = 1'b0;
          pins_d.oe_n = 1'b0;
          pins_d.dq_oe = 1'b0;
          cnt_d = fsw_pkg::RD_CYC;
          reads_d = fsw_pkg::READS_RST; // Every start begins the procedure afresh
          recheck_d = 1'b0;
          busy_d = 1'b1;
          state_d = ST_RD_ACT;
        end
      end
      ST_RD_ACT: begin
        cnt_d = cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          // Sample after access time plus synchroniser delay
          // Word is taken here, while the strobe still stands; the bus is not valid in the gap
          cur_d = dq_s2_q;
          pins_d.ce_n = 1'b1;
          pins_d.oe_n = 1'b1;
          cnt_d = fsw_pkg::RD_GAP_CYC;
          state_d = ST_RD_GAP;
        end
      end
      ST_RD_GAP: begin
        cnt_d = cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          rd_d = cur_q;
          res_d.data = cur_q;
          if (reads_q != 2'h3) begin
            reads_d = reads_q + 2'h1;
          end
          cnt_d = fsw_pkg::RD_CYC;
          if (kind_q == fsw_pkg::KIND_TIMER_CHECK) begin
            // Window timer read before or after a further sector erase
            // Optional for callers whose erase commands come close together
            res_d = '{ok: 1'b1, failed: 1'b0, still_busy: 1'b0, sector_selected: 1'b0, suspended: 1'b0,
                       timer_bit: cur_q[fsw_pkg::ERASE_TIMER_BIT], data: cur_q};
            done_d = 1'b1;
            busy_d = 1'b0;
            state_d = ST_IDLE;
          end else if (reads_q == fsw_pkg::READS_RST) begin
            // First read only stores the toggles
            pins_d.ce_n = 1'b0;
            pins_d.oe_n = 1'b0;
            state_d = ST_RD_ACT;
          end else if (!op_tog) begin
            // Steady toggle: finished, next read returns array data
            res_d = '{ok: 1'b1, failed: 1'b0, still_busy: 1'b0, sector_selected: est_tog,
                      suspended: est_tog, timer_bit: cur_q[fsw_pkg::ERASE_TIMER_BIT], data: cur_q};
            done_d = 1'b1;
            busy_d = 1'b0;
            state_d = ST_IDLE;
          end else if (recheck_q) begin
            // Still toggling after timeout seen: failed, write reset
            res_d.failed = 1'b1;
            res_d.ok = 1'b0;
            pins_d.dq = {8'h00, fsw_pkg::RESET_CMD};
            pins_d.dq_oe = 1'b1;
            pins_d.ce_n = 1'b0;
            pins_d.we_n = 1'b0;
            cnt_d = fsw_pkg::WE_CYC;
            state_d = ST_WR_ACT;
          end else if (cur_q[fsw_pkg::TIMEOUT_FLAG_BIT]) begin
            // Toggle may stop just as the timeout flag rises: one more compare
            recheck_d = 1'b1;
            pins_d.ce_n = 1'b0;
            pins_d.oe_n = 1'b0;
            state_d = ST_RD_ACT;
          end else if (abandon_i) begin
            // Leaving the poll; next start restarts from the top
            res_d = '{ok: 1'b0, failed: 1'b0, still_busy: 1'b1, sector_selected: est_tog,
                      suspended: 1'b0, timer_bit: cur_q[fsw_pkg::ERASE_TIMER_BIT], data: cur_q};
            done_d = 1'b1;
            busy_d = 1'b0;
            state_d = ST_IDLE;
          end else begin
            pins_d.ce_n = 1'b0;
            pins_d.oe_n = 1'b0;
            state_d = ST_RD_ACT;
          end
        end
      end
      ST_WR_ACT: begin
        cnt_d = cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          // Rising write strobe latches the reset command
          pins_d.we_n = 1'b1;
          pins_d.ce_n = 1'b1;
          cnt_d = fsw_pkg::WR_GAP_CYC;
          state_d = ST_WR_GAP;
        end
      end
      ST_WR_GAP: begin
        cnt_d = cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          pins_d.dq_oe = 1'b0;
          done_d = 1'b1;
          busy_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      // Illegal codes fall back to idle
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Registers only; pins come straight from flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      kind_q <= fsw_pkg::KIND_TOGGLE_POLL;
      pins_q <= '{addr: 22'h000000, dq: 16'h0000, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      res_q <= '0;
      cnt_q <= 5'h00;
      rd_q <= 16'h0000;
      cur_q <= 16'h0000;
      reads_q <= fsw_pkg::READS_RST;
      recheck_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      pins_q <= pins_d;
      res_q <= res_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      cur_q <= cur_d;
      reads_q <= reads_d;
      recheck_q <= recheck_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  assign pins_o = pins_q;
  assign done_o = done_q;
  assign busy_o = busy_q;
  assign result_o = res_q;
  assign flash_ready_o = rb_s2_q; // Busy low while the flash is programming or erasing

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_no_bus_fight: assert property (!pins_q.oe_n |-> !pins_q.dq_oe)
    else $error("data driven during read");
  chk_read_strobe_len: assert property ($fell(pins_q.oe_n) |-> (!pins_q.oe_n)[*8] ##1 (!pins_q.oe_n)[*8] ##1 pins_q.oe_n)
    else $error("read strobe length wrong");
  chk_two_reads_ok: assert property (done_q && res_q.ok && kind_q == fsw_pkg::KIND_TOGGLE_POLL |-> reads_q >= 2'h2)
    else $error("completion without two reads");
  chk_steady_done: assert property (state_q == ST_RD_GAP && cnt_q == 5'h01 && reads_q != 2'h0 && !op_tog
    && kind_q == fsw_pkg::KIND_TOGGLE_POLL |=> done_q && res_q.ok)
    else $error("steady toggle not reported done");
  chk_fail_reset: assert property ($rose(res_q.failed) |-> !pins_q.we_n && pins_q.dq[7:0] == fsw_pkg::RESET_CMD
    && $past(recheck_q))
    else $error("failure without reset write");
  chk_reset_write_end: assert property ($fell(pins_q.we_n) |-> ##7 pins_q.we_n ##4 done_q)
    else $error("reset write sequence wrong");
  chk_addr_stable: assert property (!pins_q.ce_n && $past(!pins_q.ce_n) |-> $stable(pins_q.addr))
    else $error("address moved during cycle");
  chk_timer_report: assert property (done_q && kind_q == fsw_pkg::KIND_TIMER_CHECK
    |-> res_q.timer_bit == rd_q[fsw_pkg::ERASE_TIMER_BIT])
    else $error("timer bit misreported");
  chk_restart_clean: assert property (state_q == ST_IDLE && start_i |=> reads_q == 2'h0 && !recheck_q)
    else $error("procedure not restarted");
  chk_done_pulse: assert property (done_q |=> !done_q)
    else $error("done longer than one cycle");

  cov_poll_ok: cover property (done_q && res_q.ok && kind_q == fsw_pkg::KIND_TOGGLE_POLL);
  cov_poll_fail: cover property (done_q && res_q.failed);
  cov_abandon: cover property (done_q && res_q.still_busy);
  cov_timer: cover property (done_q && res_q.timer_bit);
endmodule

/* File: core/fsw_pkg.sv */
// Constants, types and pin bundles for the flash write-status poller.
// Assumes one 200 MHz clock and an asynchronous parallel NOR flash outside.
// Summary of operation
// - Host combines both toggles for sector and mode
// - Host reads twice and compares toggle
// - Steady toggle means done, array next read
// - Toggling with timeout: recheck, then reset
// - Host restarts procedure after leaving polling
// - Reset command after timeout failure
// - Host may skip timer below gap limit
// - Host checks timer before and after command
// - Host supplies valid address for status
// - Status reads address the busy bank
package fsw_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int CNT_W = 5;
  // Status bit positions, identical in byte and word mode
  localparam int POLLING_BIT = 7;
  localparam int OPERATION_TOGGLE_BIT = 6;
  localparam int TIMEOUT_FLAG_BIT = 5;
  localparam int ERASE_TIMER_BIT = 3;
  localparam int ERASE_SECTOR_TOGGLE_BIT = 2;
  localparam logic [7:0] RESET_CMD = 8'hf0;
  // Timing in ns and derived cycle counts
  localparam int CLK_NS = 5;
  localparam int SYNC_STAGES = 2;
  localparam int RD_ACCESS_NS = 70;
  localparam int RD_GAP_NS = 20;
  localparam int WE_PULSE_NS = 35;
  localparam int WR_GAP_NS = 20;
  localparam logic [CNT_W-1:0] RD_CYC = CNT_W'((RD_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [CNT_W-1:0] RD_GAP_CYC = CNT_W'((RD_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WE_CYC = CNT_W'((WE_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WR_GAP_CYC = CNT_W'((WR_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] READS_RST = 2'h0;

  typedef enum logic {KIND_TOGGLE_POLL, KIND_TIMER_CHECK} fsw_kind_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } fsw_pins_s;

  typedef struct packed {
    logic ok;
    logic failed;
    logic still_busy;
    logic sector_selected;
    logic suspended;
    logic timer_bit;
    logic [DATA_W-1:0] data;
  } fsw_result_s;
endpackage

/* File: verif/fsw_flash_model.sv */
// Behavioural flash that answers the poller's read and write strobes.
// Assumes the bench sets the busy, sector, timeout and timer levels.
`timescale 1ns/1ps
module fsw_flash_model #(
  parameter logic [15:0] ARRAY_WORD = 16'h3c5a
) (
  input wire fsw_pkg::fsw_pins_s pins_i,
  input wire logic busy_i,
  input wire logic sector_i,
  input wire logic tmo_i,
  input wire logic timer_i,
  output logic [15:0] dq_o,
  output logic ready_busy_n_o,
  output int resets_o
);
  // ****************
  // Status outputs
  // ****************
  logic rd;
  logic t6 = 1'b0;
  logic t2 = 1'b0;
  logic [15:0] word;
  logic [15:0] last = 16'h0000;
  initial resets_o = 0;
  assign rd = ~pins_i.ce_n & ~pins_i.oe_n;
  // Status in the low byte for either bus width
  assign word = (busy_i | sector_i) ? {8'h00, ~busy_i, t6, tmo_i, 1'b0, timer_i, t2, 2'h0} : ARRAY_WORD;
  // Released bus shows the inverse, so a late sample cannot pass by luck
  assign dq_o = rd ? word : ~last;
  assign ready_busy_n_o = ~busy_i;
  // Toggles advance at the end of every read, t6 only while busy_i is high and t2 only while sector_i is high
  always @(negedge rd) begin
    last = word;
    t6 = t6 ^ busy_i;
    t2 = t2 ^ sector_i;
  end
  // Reset command write, counted for the bench
  always @(posedge pins_i.we_n) begin
    if (pins_i.dq[7:0] === 8'hf0) resets_o = resets_o + 1;
  end
endmodule

/* File: verif/flash_write_status_reporting_tb_top.sv */
// Self-checking bench for the write-status poller.
// Assumes the flash model above stands on the pin side.
`timescale 1ns/1ps
module flash_write_status_reporting_tb_top;
  // ****************
  // Stimulus and wiring
  // ****************
  localparam logic [15:0] ARRAY = 16'h3c5a;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic start_i = 1'b0;
  fsw_pkg::fsw_kind_e kind_i = fsw_pkg::KIND_TOGGLE_POLL;
  logic [fsw_pkg::ADDR_W-1:0] addr_i = 22'h041000;
  logic abandon_i = 1'b0;
  logic bsy = 1'b0;
  logic sec = 1'b0;
  logic tmo = 1'b0;
  logic tmr = 1'b0;
  logic [15:0] dq;
  logic rdy_n;
  fsw_pkg::fsw_pins_s pins;
  fsw_pkg::fsw_result_s res;
  logic busy;
  logic done;
  logic fr;
  int resets;
  int num_errors = 0;
  int cmp_count = 0;
  always #2.5 clk_i = ~clk_i;
  fsw_poller i_fsw_poller (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .kind_i(kind_i),
    .addr_i(addr_i), .abandon_i(abandon_i), .dq_i(dq), .ready_busy_n_i(rdy_n), .pins_o(pins),
    .busy_o(busy), .done_o(done), .result_o(res), .flash_ready_o(fr));
  fsw_flash_model #(.ARRAY_WORD(ARRAY)) i_fsw_flash_model (.pins_i(pins), .busy_i(bsy), .sector_i(sec),
    .tmo_i(tmo), .timer_i(tmr), .dq_o(dq), .ready_busy_n_o(rdy_n), .resets_o(resets));
  // Shared compare
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One request, waited on under a bound
  task automatic run(input fsw_pkg::fsw_kind_e k);
    int n;
    @(negedge clk_i);
    kind_i = k;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    chk("busy set", 32'(busy), 32'h1);
    n = 0;
    while (done !== 1'b1 && n < 500) begin
      @(negedge clk_i);
      n++;
    end
    chk("done", 32'(done), 32'h1);
    chk("busy clear", 32'(busy), 32'h0);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_ready();
    bsy = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("ready low", 32'(fr), 32'h0);
    bsy = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("ready high", 32'(fr), 32'h1);
  endtask
  task automatic t_array();
    run(fsw_pkg::KIND_TOGGLE_POLL);
    chk("ok", 32'(res.ok), 32'h1);
    chk("data", 32'(res.data), 32'(ARRAY));
  endtask
  task automatic t_suspend();
    sec = 1'b1;
    run(fsw_pkg::KIND_TOGGLE_POLL);
    chk("suspended", 32'(res.suspended), 32'h1);
    chk("sector", 32'(res.sector_selected), 32'h1);
    sec = 1'b0;
  endtask
  task automatic t_timer();
    bsy = 1'b1;
    for (int v = 0; v < 2; v++) begin
      tmr = v[0]; // Window end raises the timer bit, sector erase only
      run(fsw_pkg::KIND_TIMER_CHECK);
      chk("timer", 32'(res.timer_bit), 32'(v));
    end
  endtask
  task automatic t_abandon();
    tmo = 1'b0;
    abandon_i = 1'b0;
    fork
      begin
        repeat (150) @(negedge clk_i);
        abandon_i = 1'b1;
      end
    join_none
    run(fsw_pkg::KIND_TOGGLE_POLL);
    chk("still", 32'(res.still_busy), 32'h1);
    chk("ok busy", 32'(res.ok), 32'h0);
    abandon_i = 1'b0;
  endtask
  task automatic t_fail();
    int r0;
    r0 = resets;
    tmo = 1'b1; // Halted write past its pulse limit
    run(fsw_pkg::KIND_TOGGLE_POLL);
    chk("failed", 32'(res.failed), 32'h1);
    chk("resets", 32'(resets), 32'(r0 + 1));
    bsy = 1'b0;
    tmo = 1'b0;
    t_array();
  endtask
  // Watchdog on the whole run
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_ready();
    t_array();
    t_suspend();
    t_timer();
    t_abandon();
    t_fail();
    stop_test();
  end
endmodule
